// [rtl/dss_apb_slave.sv]
`timescale 1ns/100ps
module dss_apb_slave (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CE,
    // APB
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Register side
    dss_reg_if.slave         r
);

    // ****************************************
    // Access phase: one wait state, then ready
    // ****************************************
    // The wait state lets read data come from a flop
    assign r.addr  = I_PADDR;
    assign r.wdata = I_PWDATA;
    assign r.wr    = I_CE & I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= '0;
            O_PSLVERR <= 1'b0;
        end
        else if (I_CE)
        begin
            if (I_PSEL && I_PENABLE && !O_PREADY)
            begin
                O_PREADY  <= 1'b1;
                O_PRDATA  <= I_PWRITE ? 32'h0 : r.rdata;
                O_PSLVERR <= ~r.hit;
            end
            else
            begin
                O_PREADY  <= 1'b0;
                O_PSLVERR <= 1'b0;
            end
        end
    end

endmodule

// [rtl/dss_filter_bank.sv]
`timescale 1ns/100ps
module dss_filter_bank #(
    parameter int N = 16
) (
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_RST_N,
    // Qualifier lanes
    dss_flt_if.bank   f
);

    // ****************************************
    // One qualifier per MOSFET
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_lane
            logic [dss_pkg::CNT_W-1:0] cnt_reg;
            logic                      pre_reg;
            logic                      fault_reg;
            logic [dss_pkg::CNT_W-1:0] lim;

            // A short seen during blanking needs two filter windows
            assign lim = pre_reg ? dss_pkg::CNT_W'(f.limit << 1) : f.limit;
            assign f.fault[i] = fault_reg;

            always_ff @(posedge I_CLK or negedge I_RST_N)
            begin
                if (!I_RST_N)
                begin
                    cnt_reg   <= '0;
                    pre_reg   <= 1'b0;
                    fault_reg <= 1'b0;
                end
                else if (f.ce)
                begin
                    fault_reg <= 1'b0;
                    if (!f.mon_en || !f.on[i])
                    begin
                        cnt_reg <= '0;
                        pre_reg <= 1'b0;
                    end
                    else if (!f.blank_done[i])
                    begin
                        cnt_reg <= '0;
                        pre_reg <= pre_reg | f.cmp[i];
                    end
                    else if (!f.cmp[i])
                    begin
                        cnt_reg <= '0;
                        pre_reg <= 1'b0;
                    end
                    else if (cnt_reg == lim)
                    begin
                        fault_reg <= 1'b1;
                        cnt_reg   <= '0;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

// [rtl/dss_if.sv]
`timescale 1ns/100ps
interface dss_flt_if #(parameter int N = 16);
    logic                      ce;
    logic                      mon_en;
    logic [N-1:0]              on;
    logic [N-1:0]              blank_done;
    logic [N-1:0]              cmp;
    logic [dss_pkg::CNT_W-1:0] limit;
    logic [N-1:0]              fault;
    modport top  (output ce, mon_en, on, blank_done, cmp, limit, input fault);
    modport bank (input ce, mon_en, on, blank_done, cmp, limit, output fault);
endinterface

interface dss_reg_if;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;
    modport slave (output wr, addr, wdata, input rdata, hit);
    modport top   (input wr, addr, wdata, output rdata, hit);
endinterface

// [rtl/dss_pkg.sv]
package dss_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_GEN_CTRL   = 8'h00;
    localparam logic [7:0] OFS_THR_A      = 8'h04;
    localparam logic [7:0] OFS_THR_B      = 8'h08;
    localparam logic [7:0] OFS_REF_SEL    = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_GLOBAL     = 8'h14;
    localparam logic [7:0] OFS_MASK       = 8'h18;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int         NUM_BRIDGES    = 8;
    localparam int         THR_W          = 3;
    localparam int         GC_PASSIVE_BIT = 0;
    localparam int         GC_FILT_LSB    = 1;
    localparam int         GLB_SUMMARY    = 0;
    localparam logic [2:0] THR_RST        = 3'h1;
    localparam logic [11:0] THR_HALF_RST  = {4{THR_RST}};
    localparam logic [1:0] FILT_RST       = 2'h0;
    localparam logic [7:0] REF_SEL_RST    = 8'h00;
    localparam logic [7:0] MASK_RST       = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         FILT0_NS       = 500;
    localparam int         FILT1_NS       = 1000;
    localparam int         FILT2_NS       = 2000;
    localparam int         FILT3_NS       = 3000;
    localparam int         CNT_W          = 7;
    localparam logic [CNT_W-1:0] FILT0_CYC = CNT_W'((FILT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FILT1_CYC = CNT_W'((FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FILT2_CYC = CNT_W'((FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FILT3_CYC = CNT_W'((FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    function automatic logic [CNT_W-1:0] filt_cycles(input logic [1:0] code);
        case (code)
            2'h0:    filt_cycles = FILT0_CYC;
            2'h1:    filt_cycles = FILT1_CYC;
            2'h2:    filt_cycles = FILT2_CYC;
            default: filt_cycles = FILT3_CYC;
        endcase
    endfunction

endpackage

// [rtl/dss_short_monitor.sv]
// Operation
// - Monitor only when enabled and bridge active
// - Qualified fault latches the half-bridge off
// - High-side ref select 0: drain-high comparator
// - High-side ref select 1: current-sense comparator
// - Low-side short seen via low-side source comparator
// - Per-bridge 3-bit threshold, reset code 001
// - Fault needs blank expired plus filter time
// - Global 2-bit filter time, reset 0.5 us
// - Short before blank end: two filter times
// - Latched bridge discharges with static current
// - Fault sets the bridge status bit
// - Fault sets the global summary flag
// - Bridge stays off until status cleared
`timescale 1ns/100ps
module dss_short_monitor (
    // Clock, reset, enable
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CE,
    // APB
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Device state
    input  wire logic        I_EN,
    // Gate commands from the bridge control
    input  wire logic [7:0]  I_HS_ON,
    input  wire logic [7:0]  I_LS_ON,
    // Blank-time generator
    input  wire logic [7:0]  I_HS_BLANK_DONE,
    input  wire logic [7:0]  I_LS_BLANK_DONE,
    // Comparator results
    input  wire logic [7:0]  I_CMP_DRAIN_HIGH,
    input  wire logic [7:0]  I_CMP_CURRENT_SENSE,
    input  wire logic [7:0]  I_CMP_LOW_SIDE,
    // Gate drive and analog settings
    output logic      [7:0]  O_HS_GATE,
    output logic      [7:0]  O_LS_GATE,
    output logic      [7:0]  O_STATIC_DISCHARGE,
    output logic      [23:0] O_BRIDGE_SHORT_THRESHOLD,
    output logic      [7:0]  O_HIGH_SIDE_REF_SELECT,
    // Status
    output logic             O_SHORT_SUMMARY_FLAG,
    output logic             O_IRQ
);

    localparam int NB = dss_pkg::NUM_BRIDGES;

    // ****************************************
    // Registers
    // ****************************************
    logic              passive_bridge_select_reg;
    logic [1:0]        short_filter_time_reg;
    logic [11:0]       threshold_cfg_a_reg;
    logic [11:0]       threshold_cfg_b_reg;
    logic [NB-1:0]     high_side_ref_select_reg;
    logic [NB-1:0]     short_status_reg;
    logic [NB-1:0]     short_status_next;
    logic [NB-1:0]     irq_mask_reg;
    logic [NB-1:0]     status_set;
    logic [NB-1:0]     status_clr;
    logic [NB-1:0]     hs_cmp;
    logic [NB-1:0]     hs_gate_next;
    logic [NB-1:0]     ls_gate_next;

    dss_reg_if               rif ();
    dss_flt_if #(.N(2 * NB)) fif ();

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            dss_pkg::OFS_GEN_CTRL,
            dss_pkg::OFS_THR_A,
            dss_pkg::OFS_THR_B,
            dss_pkg::OFS_REF_SEL,
            dss_pkg::OFS_STATUS,
            dss_pkg::OFS_GLOBAL,
            dss_pkg::OFS_MASK: is_mapped = 1'b1;
            default:           is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic wr_to(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        wr_to = wr && (a == ofs);
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    dss_apb_slave u_apb (
        .I_CLK     (I_CLK),
        .I_RST_N   (I_RST_N),
        .I_CE      (I_CE),
        .I_PSEL    (I_PSEL),
        .I_PENABLE (I_PENABLE),
        .I_PWRITE  (I_PWRITE),
        .I_PADDR   (I_PADDR),
        .I_PWDATA  (I_PWDATA),
        .O_PRDATA  (O_PRDATA),
        .O_PREADY  (O_PREADY),
        .O_PSLVERR (O_PSLVERR),
        .r         (rif.slave)
    );

    assign rif.hit = is_mapped(rif.addr);

    always_comb
    begin
        rif.rdata = 32'h0;
        case (rif.addr)
            dss_pkg::OFS_GEN_CTRL:
            begin
                rif.rdata[dss_pkg::GC_PASSIVE_BIT] = passive_bridge_select_reg;
                rif.rdata[dss_pkg::GC_FILT_LSB +: 2] = short_filter_time_reg;
            end
            dss_pkg::OFS_THR_A:   rif.rdata[11:0] = threshold_cfg_a_reg;
            dss_pkg::OFS_THR_B:   rif.rdata[11:0] = threshold_cfg_b_reg;
            dss_pkg::OFS_REF_SEL: rif.rdata[NB-1:0] = high_side_ref_select_reg;
            dss_pkg::OFS_STATUS:  rif.rdata[NB-1:0] = short_status_reg;
            dss_pkg::OFS_GLOBAL:  rif.rdata[dss_pkg::GLB_SUMMARY] = O_SHORT_SUMMARY_FLAG;
            dss_pkg::OFS_MASK:    rif.rdata[NB-1:0] = irq_mask_reg;
            default:              rif.rdata = 32'h0;
        endcase
    end

    // ****************************************
    // Configuration
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            passive_bridge_select_reg <= 1'b0;
            short_filter_time_reg     <= dss_pkg::FILT_RST;
        end
        else if (I_CE && wr_to(rif.wr, rif.addr, dss_pkg::OFS_GEN_CTRL))
        begin
            passive_bridge_select_reg <= rif.wdata[dss_pkg::GC_PASSIVE_BIT];
            short_filter_time_reg     <= rif.wdata[dss_pkg::GC_FILT_LSB +: 2];
        end
    end

    // Code 111 is accepted; keeping it only for diagnosis is up to software
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            threshold_cfg_a_reg <= dss_pkg::THR_HALF_RST;
            threshold_cfg_b_reg <= dss_pkg::THR_HALF_RST;
        end
        else if (I_CE)
        begin
            if (wr_to(rif.wr, rif.addr, dss_pkg::OFS_THR_A))
            begin
                threshold_cfg_a_reg <= rif.wdata[11:0];
            end
            if (wr_to(rif.wr, rif.addr, dss_pkg::OFS_THR_B))
            begin
                threshold_cfg_b_reg <= rif.wdata[11:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            high_side_ref_select_reg <= dss_pkg::REF_SEL_RST;
        end
        else if (I_CE && wr_to(rif.wr, rif.addr, dss_pkg::OFS_REF_SEL))
        begin
            high_side_ref_select_reg <= rif.wdata[NB-1:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            irq_mask_reg <= dss_pkg::MASK_RST;
        end
        else if (I_CE && wr_to(rif.wr, rif.addr, dss_pkg::OFS_MASK))
        begin
            irq_mask_reg <= rif.wdata[NB-1:0];
        end
    end

    // ****************************************
    // Comparator selection and qualification
    // ****************************************
    // Inputs are already in this clock domain, so no synchroniser here
    assign hs_cmp = (high_side_ref_select_reg & I_CMP_CURRENT_SENSE)
                  | (~high_side_ref_select_reg & I_CMP_DRAIN_HIGH);

    assign fif.ce         = I_CE;
    assign fif.mon_en     = I_EN & ~passive_bridge_select_reg;
    assign fif.on         = {O_LS_GATE, O_HS_GATE};
    assign fif.blank_done = {I_LS_BLANK_DONE, I_HS_BLANK_DONE};
    assign fif.cmp        = {I_CMP_LOW_SIDE, hs_cmp};
    assign fif.limit      = dss_pkg::filt_cycles(short_filter_time_reg);

    dss_filter_bank #(.N(2 * NB)) u_filt (
        .I_CLK   (I_CLK),
        .I_RST_N (I_RST_N),
        .f       (fif.bank)
    );

    // ****************************************
    // Fault status
    // ****************************************
    // A new fault in the clearing cycle survives the clear
    assign status_set = fif.fault[NB-1:0] | fif.fault[2*NB-1:NB];
    assign status_clr = wr_to(rif.wr, rif.addr, dss_pkg::OFS_STATUS) ? rif.wdata[NB-1:0]
                                                                       : '0;
    assign short_status_next = (short_status_reg & ~status_clr) | status_set;

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            short_status_reg <= '0;
        end
        else if (I_CE)
        begin
            short_status_reg <= short_status_next;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_SHORT_SUMMARY_FLAG <= 1'b0;
        end
        else if (I_CE)
        begin
            O_SHORT_SUMMARY_FLAG <= |short_status_next;
        end
    end

    // Taken from the next status so the line rises together with the status bit
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_IRQ <= 1'b0;
        end
        else if (I_CE)
        begin
            O_IRQ <= |(short_status_next & irq_mask_reg);
        end
    end

    // ****************************************
    // Gate drive and analog setting outputs
    // ****************************************
    // A latched bridge ignores commands until its status bit is cleared
    assign hs_gate_next = I_HS_ON & ~short_status_next;
    assign ls_gate_next = I_LS_ON & ~short_status_next;

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_HS_GATE          <= '0;
            O_LS_GATE          <= '0;
            O_STATIC_DISCHARGE <= '0;
        end
        else if (I_CE)
        begin
            O_HS_GATE          <= hs_gate_next;
            O_LS_GATE          <= ls_gate_next;
            O_STATIC_DISCHARGE <= short_status_next;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_BRIDGE_SHORT_THRESHOLD <= {dss_pkg::THR_HALF_RST, dss_pkg::THR_HALF_RST};
        end
        else if (I_CE)
        begin
            O_BRIDGE_SHORT_THRESHOLD <= {threshold_cfg_b_reg, threshold_cfg_a_reg};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_HIGH_SIDE_REF_SELECT <= dss_pkg::REF_SEL_RST;
        end
        else if (I_CE)
        begin
            O_HIGH_SIDE_REF_SELECT <= high_side_ref_select_reg;
        end
    end

endmodule

// [verif/dss_fet_model.sv]
`timescale 1ns/100ps
module dss_fet_model (
    // Gate drive and sense selection
    input  wire logic [7:0] i_hs,
    input  wire logic [7:0] i_ls,
    input  wire logic [7:0] i_sel,
    // Injected faults
    input  wire logic [7:0] i_hs_sh,
    input  wire logic [7:0] i_ls_sh,
    input  wire logic [7:0] i_decoy,
    // Comparator results
    output logic      [7:0] o_dh,
    output logic      [7:0] o_cs,
    output logic      [7:0] o_lsc
);
    // ********
    // Comparators
    // ********
    // A short shows only while the FET is on, so a latched bridge drops it
    // Decoy puts an overvoltage on the path that is not selected
    assign o_dh = i_hs & ((~i_sel & i_hs_sh) | (i_sel & i_decoy));
    assign o_cs = i_hs & ((i_sel & i_hs_sh) | (~i_sel & i_decoy));
    assign o_lsc = i_ls & i_ls_sh;
endmodule

// [verif/dss_short_monitor_asserts.sv]
`timescale 1ns/100ps
module dss_short_monitor_asserts (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // APB
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic        O_PREADY,
    // Monitor inputs
    input  wire logic        I_EN,
    input  wire logic [7:0]  I_HS_ON,
    input  wire logic [7:0]  I_LS_ON,
    input  wire logic [7:0]  I_HS_BLANK_DONE,
    input  wire logic [7:0]  I_LS_BLANK_DONE,
    input  wire logic [7:0]  I_CMP_DRAIN_HIGH,
    input  wire logic [7:0]  I_CMP_CURRENT_SENSE,
    input  wire logic [7:0]  I_CMP_LOW_SIDE,
    // Monitor outputs
    input  wire logic [7:0]  O_HS_GATE,
    input  wire logic [7:0]  O_LS_GATE,
    input  wire logic [7:0]  O_STATIC_DISCHARGE,
    input  wire logic [23:0] O_BRIDGE_SHORT_THRESHOLD,
    input  wire logic        O_SHORT_SUMMARY_FLAG,
    input  wire logic        O_IRQ
);
    wire logic any_cmp = |(I_CMP_DRAIN_HIGH | I_CMP_CURRENT_SENSE | I_CMP_LOW_SIDE);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // ********
    // Assertions
    // ********
    property p_gate_off;
        ((O_HS_GATE | O_LS_GATE) & O_STATIC_DISCHARGE) == 8'h00;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gate on in latched bridge");
    property p_gate_cmd;
        ((O_HS_GATE & ~$past(I_HS_ON)) | (O_LS_GATE & ~$past(I_LS_ON))) == 8'h00;
    endproperty
    a_gate_cmd: assert property (p_gate_cmd)
        else $error("gate on without command");
    property p_clear;
        (($past(O_STATIC_DISCHARGE) & ~O_STATIC_DISCHARGE) != 8'h00) |->
            $past(I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == 8'h10);
    endproperty
    a_clear: assert property (p_clear)
        else $error("latch released without status write");
    property p_en;
        $rose(O_SHORT_SUMMARY_FLAG) |-> $past(I_EN, 2) && $past(I_EN, 7);
    endproperty
    a_en: assert property (p_en)
        else $error("fault while monitoring disabled");
    property p_blank;
        (O_STATIC_DISCHARGE & ~$past(O_STATIC_DISCHARGE)
            & ~$past(I_HS_BLANK_DONE | I_LS_BLANK_DONE, 2)) == 8'h00;
    endproperty
    a_blank: assert property (p_blank)
        else $error("fault before blank expired");
    property p_cmp;
        $rose(O_SHORT_SUMMARY_FLAG) |-> $past(any_cmp, 2) && $past(any_cmp, 7);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("fault without held comparator");
    property p_sum;
        O_SHORT_SUMMARY_FLAG == (O_STATIC_DISCHARGE != 8'h00);
    endproperty
    a_sum: assert property (p_sum)
        else $error("summary differs from latched bridges");
    property p_irq;
        O_IRQ |-> O_SHORT_SUMMARY_FLAG;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without status");
    property p_thr;
        !$stable(O_BRIDGE_SHORT_THRESHOLD) |-> $past(I_PWRITE && O_PREADY, 2);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold changed without write");
    c_fault: cover property ($rose(O_SHORT_SUMMARY_FLAG));
    c_irq: cover property ($rose(O_IRQ));
    c_clear: cover property ($fell(O_SHORT_SUMMARY_FLAG));
endmodule

bind dss_short_monitor dss_short_monitor_asserts u_chk (
    .I_CLK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PREADY, .I_EN,
    .I_HS_ON, .I_LS_ON, .I_HS_BLANK_DONE, .I_LS_BLANK_DONE, .I_CMP_DRAIN_HIGH,
    .I_CMP_CURRENT_SENSE, .I_CMP_LOW_SIDE, .O_HS_GATE, .O_LS_GATE, .O_STATIC_DISCHARGE,
    .O_BRIDGE_SHORT_THRESHOLD, .O_SHORT_SUMMARY_FLAG, .O_IRQ
);

// [verif/tb_drain_source_short_monitor.sv]
`timescale 1ns/100ps
module tb_drain_source_short_monitor;
    // ********
    // Signals
    // ********
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        en = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  hs_on = 8'h00;
    logic [7:0]  ls_on = 8'h00;
    logic [7:0]  hs_blk = 8'hff;
    logic [7:0]  ls_blk = 8'hff;
    logic [7:0]  hs_sh = 8'h00;
    logic [7:0]  ls_sh = 8'h00;
    logic [7:0]  decoy = 8'h00;
    logic [31:0] rd;
    logic [31:0] prdata;
    logic        err;
    logic        pready;
    logic        pslverr;
    logic        sum;
    logic        irq;
    logic [7:0]  dh, cs, lsc, hs_g, ls_g, dis, refs;
    logic [23:0] thr;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    // Filter times in 100 ns clocks
    int          filt_l [4] = '{5, 10, 20, 30};
    logic [7:0]  ofs [7] = '{dss_pkg::OFS_GEN_CTRL, dss_pkg::OFS_THR_A, dss_pkg::OFS_THR_B,
        dss_pkg::OFS_REF_SEL, dss_pkg::OFS_STATUS, dss_pkg::OFS_GLOBAL, dss_pkg::OFS_MASK};
    logic [31:0] rv [7] = '{32'h0, 32'h249, 32'h249, 32'h0, 32'h0, 32'h0, 32'h0};

    always #50 clk = ~clk;

    dss_short_monitor uut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EN(en), .I_HS_ON(hs_on), .I_LS_ON(ls_on),
        .I_HS_BLANK_DONE(hs_blk), .I_LS_BLANK_DONE(ls_blk), .I_CMP_DRAIN_HIGH(dh),
        .I_CMP_CURRENT_SENSE(cs), .I_CMP_LOW_SIDE(lsc), .O_HS_GATE(hs_g), .O_LS_GATE(ls_g),
        .O_STATIC_DISCHARGE(dis), .O_BRIDGE_SHORT_THRESHOLD(thr),
        .O_HIGH_SIDE_REF_SELECT(refs), .O_SHORT_SUMMARY_FLAG(sum), .O_IRQ(irq)
    );

    dss_fet_model u_fet (
        .i_hs(hs_g), .i_ls(ls_g), .i_sel(refs), .i_hs_sh(hs_sh), .i_ls_sh(ls_sh),
        .i_decoy(decoy), .o_dh(dh), .o_cs(cs), .o_lsc(lsc)
    );

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Entered just after an edge; one spare edge at the end avoids double drives
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic hit(input logic [7:0] m, input int e);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (sum !== 1'b1 && n < 100);
        chk(n, e);
        chk(dis, m);
        chk((hs_g | ls_g) & m, 8'h00);
        chk(irq, m[0]);
        hs_sh <= 8'h00;
        ls_sh <= 8'h00;
        repeat (4) @(posedge clk);
        chk((hs_g | ls_g) & m, 8'h00);
        apb(1'b0, dss_pkg::OFS_STATUS, 32'h0);
        chk(rd, m);
        apb(1'b0, dss_pkg::OFS_GLOBAL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, dss_pkg::OFS_STATUS, 32'(m));
        repeat (2) @(posedge clk);
        chk(sum, 1'b0);
        chk((hs_g | ls_g) & m, (hs_on | ls_on) & m);
    endtask

    // ********
    // Timeout
    // ********
    // Whole run needs about 500 clocks
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ********
    // Tests
    // ********
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(thr, 24'h249249);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, dss_pkg::OFS_GLOBAL, 32'h1);
        apb(1'b0, dss_pkg::OFS_GLOBAL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, dss_pkg::OFS_THR_A, 32'hfff);
        @(posedge clk);
        chk(thr[11:0], 12'hfff);
        apb(1'b1, dss_pkg::OFS_THR_A, 32'h249);
        $display("test registers done");
        apb(1'b1, dss_pkg::OFS_REF_SEL, 32'h0a);
        apb(1'b1, dss_pkg::OFS_MASK, 32'h01);
        chk(refs, 32'h0a);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, dss_pkg::OFS_GEN_CTRL, 32'(c << 1));
            hs_on <= 8'(1 << c);
            repeat (2) @(posedge clk);
            hs_sh <= 8'(1 << c);
            hit(8'(1 << c), filt_l[c] + 3);
            hs_on <= 8'h00;
        end
        $display("test filter times done");
        apb(1'b1, dss_pkg::OFS_GEN_CTRL, 32'h0);
        hs_on <= 8'hff;
        decoy <= 8'hff;
        repeat (40) @(posedge clk);
        chk(sum, 1'b0);
        decoy <= 8'h00;
        hs_on <= 8'h04;
        hs_sh <= 8'h04;
        en <= 1'b0;
        repeat (40) @(posedge clk);
        chk(sum, 1'b0);
        en <= 1'b1;
        hs_sh <= 8'h00;
        apb(1'b1, dss_pkg::OFS_GEN_CTRL, 32'h1);
        hs_sh <= 8'h04;
        repeat (40) @(posedge clk);
        chk(sum, 1'b0);
        hs_sh <= 8'h00;
        apb(1'b1, dss_pkg::OFS_GEN_CTRL, 32'h0);
        hs_sh <= 8'h04;
        hit(8'h04, 8);
        $display("test enable done");
        ls_on <= 8'h80;
        repeat (2) @(posedge clk);
        ls_sh <= 8'h80;
        hit(8'h80, 8);
        ls_on <= 8'h00;
        hs_sh <= 8'h04;
        repeat (5) @(posedge clk);
        hs_sh <= 8'h00;
        @(posedge clk);
        hs_sh <= 8'h04;
        hit(8'h04, 8);
        hs_blk <= 8'hfb;
        hs_sh <= 8'h04;
        repeat (5) @(posedge clk);
        chk(sum, 1'b0);
        hs_blk <= 8'hff;
        hit(8'h04, 13);
        $display("test low side, restart and blank done");
        close_out();
    end
endmodule
